// *** logic/exec_pkg.sv ***
package exec_pkg;
	localparam int INSTR_W = 14;
	localparam int ADDR_W  = 7;
	localparam int DATA_W  = 8;
	localparam int PC_W    = 13;
	// Opcode of move accumulator to file: 00 0000 1fff ffff.
	localparam logic [6:0] MOVE_ACC_OP    = 7'h01;
	localparam logic [13:0] NOP_MASK      = 14'h3F9F;
	localparam logic [13:0] NOP_CODE      = 14'h0000;
	localparam logic [13:0] LOAD_CFG_CODE = 14'h0062;
	localparam logic [13:0] IRQ_RET_CODE  = 14'h0009;
	localparam int GLOBAL_EN_BIT          = 7;
	// File address at which the prescaler configuration register is seen.
	localparam logic [6:0] CFG_ADDR       = 7'h01;
	localparam logic [7:0] CFG_RESET      = 8'hFF;
	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;
endpackage : exec_pkg

// *** logic/cfg_reg.sv ***
`timescale 1ns/1ps
module cfg_reg
	import exec_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              write_in,
	input  wire logic [DATA_W-1:0] data_in,
	output logic      [DATA_W-1:0] value_out
);
	logic [DATA_W-1:0] value;
	logic [DATA_W-1:0] next_value;

	always_comb begin
		next_value = write_in ? data_in : value;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			value <= CFG_RESET;
		end else begin
			value <= next_value;
		end
	end

	assign value_out = value;
endmodule : cfg_reg

// *** logic/misc_instr_exec_subset.sv ***
// Contract
// - No-op, don't-care bits included, changes nothing but PC; one cycle.
// - Load-config copies accumulator into prescaler config, flags kept.
// - Prescaler config is readable and writable by file addressing.
// - Interrupt return pops stack into PC in Q4 of first cycle.
// - Interrupt return sets global enable, control bit 7, in Q3.
// - Interrupt return takes two cycles; second cycle does nothing.
// - No-op decodes in Q1 and only advances PC, in Q4.
`timescale 1ns/1ps
module misc_instr_exec_subset
	import exec_pkg::*;
(
	input  wire logic               clock_in,
	input  wire logic               rst_in,
	input  wire logic [INSTR_W-1:0] instr_in,
	input  wire logic [DATA_W-1:0]  acc_in,
	input  wire logic [PC_W-1:0]    stack_top_in,
	input  wire logic [DATA_W-1:0]  file_wr_data_in,
	input  wire logic [ADDR_W-1:0]  file_wr_addr_in,
	input  wire logic               file_wr_in,
	input  wire logic [ADDR_W-1:0]  file_rd_addr_in,
	output logic [1:0]              phase_out,
	output logic                    file_we_out,
	output logic [ADDR_W-1:0]       file_addr_out,
	output logic [DATA_W-1:0]       file_wdata_out,
	output logic [DATA_W-1:0]       cfg_out,
	output logic [DATA_W-1:0]       cfg_rdata_out,
	output logic                    cfg_hit_out,
	output logic                    stack_pop_out,
	output logic                    pc_load_out,
	output logic [PC_W-1:0]         pc_value_out,
	output logic                    pc_advance_out,
	output logic                    global_en_set_out,
	output logic                    busy_out
);
	// All checks sample on the core clock and rest while reset is held.
	default clocking chk_clk @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	// ****************************************
	// Phase and decode state
	// ****************************************
	phase_e             phase;
	phase_e             next_phase;
	logic               second;
	logic               next_second;
	logic [INSTR_W-1:0] ir;
	logic [INSTR_W-1:0] next_ir;
	logic [DATA_W-1:0]  latch;
	logic [DATA_W-1:0]  next_latch;
	logic [PC_W-1:0]    target;
	logic [PC_W-1:0]    next_target;
	logic               is_move;
	logic               is_nop;
	logic               is_cfg;
	logic               is_ret;

	assign is_move = ir[INSTR_W-1:ADDR_W] == MOVE_ACC_OP;
	assign is_nop  = (ir & NOP_MASK) == NOP_CODE;
	assign is_cfg  = ir == LOAD_CFG_CODE;
	assign is_ret  = ir == IRQ_RET_CODE;

	always_comb begin
		next_phase  = phase;
		next_second = second;
		next_ir     = ir;
		next_latch  = latch;
		next_target = target;
		unique case (phase)
			PH_Q1: begin
				next_phase = PH_Q2;
				if (!second) begin
					next_ir = instr_in;
				end
			end
			PH_Q2: begin
				next_phase = PH_Q3;
				if (!second) begin
					next_latch = acc_in;
				end
			end
			PH_Q3: begin
				next_phase = PH_Q4;
				if (!second) begin
					next_target = stack_top_in;
				end
			end
			PH_Q4: begin
				next_phase  = PH_Q1;
				next_second = !second && is_ret;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			phase  <= PH_Q1;
			second <= 1'b0;
			ir     <= NOP_CODE;
			latch  <= '0;
			target <= '0;
		end else begin
			phase  <= next_phase;
			second <= next_second;
			ir     <= next_ir;
			latch  <= next_latch;
			target <= next_target;
		end
	end

	// ****************************************
	// Execute actions
	// ****************************************
	logic act;
	logic cfg_load;
	logic cfg_file_wr;

	assign act = !second && phase == PH_Q4;
	assign file_we_out    = act && is_move;
	assign file_addr_out  = ir[ADDR_W-1:0];
	assign file_wdata_out = latch;
	assign cfg_file_wr    = file_wr_in && file_wr_addr_in == CFG_ADDR;
	assign cfg_load       = (act && (is_cfg || (is_move &&
		ir[ADDR_W-1:0] == CFG_ADDR))) || cfg_file_wr;
	assign stack_pop_out  = act && is_ret;
	assign pc_load_out    = act && is_ret;
	assign pc_value_out   = target;
	assign global_en_set_out = !second && phase == PH_Q3 && is_ret;
	assign pc_advance_out = act && !is_ret;
	assign busy_out       = second;
	assign phase_out      = phase;
	assign cfg_hit_out    = file_rd_addr_in == CFG_ADDR;
	assign cfg_rdata_out  = cfg_out;

	cfg_reg u_cfg (
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.write_in  (cfg_load),
		.data_in   (cfg_file_wr ? file_wr_data_in : latch),
		.value_out (cfg_out)
	);

	// ****************************************
	// Checks
	// ****************************************
	// An instruction word taken at a first-cycle Q1 edge.
	sequence move_taken;
		phase == PH_Q1 && !second &&
			instr_in[INSTR_W-1:ADDR_W] == MOVE_ACC_OP;
	endsequence

	sequence nop_taken;
		phase == PH_Q1 && !second && (instr_in & NOP_MASK) == NOP_CODE;
	endsequence

	sequence ret_taken;
		phase == PH_Q1 && !second && instr_in == IRQ_RET_CODE;
	endsequence

	sequence ret_first_q3;
		!second && phase == PH_Q3 && is_ret;
	endsequence

	sequence ret_pop_q4;
		stack_pop_out && pc_load_out && !pc_advance_out;
	endsequence

	// Four clocks in which the second return cycle shows no effect at all.
	sequence idle_cycle;
		(second && !file_we_out && !stack_pop_out && !pc_load_out &&
			!pc_advance_out && !global_en_set_out)[*4];
	endsequence

	chk_ret_enable: assert property (
		ret_first_q3 |=> ret_pop_q4)
		else $error("Return pop did not follow the enable phase.");

	chk_ret_idle: assert property (
		stack_pop_out |=> idle_cycle)
		else $error("Second return cycle was not idle.");

	chk_gie_q3: assert property (
		global_en_set_out |-> phase == PH_Q3 && !second)
		else $error("Global enable set outside the first Q3.");

	chk_move_data: assert property (
		file_we_out |-> file_wdata_out == $past(acc_in, 2))
		else $error("File write data is not the accumulator.");

	chk_move_write: assert property (
		move_taken |-> ##3 (file_we_out &&
			file_addr_out == $past(instr_in[ADDR_W-1:0], 3)))
		else $error("Move did not write the addressed register in Q4.");

	chk_cfg_load: assert property (
		act && is_cfg && !cfg_file_wr |=> cfg_out == $past(latch))
		else $error("Load-config did not copy the accumulator.");

	chk_cfg_move: assert property (
		act && is_move && file_addr_out == CFG_ADDR && !cfg_file_wr |=>
			cfg_out == $past(file_wdata_out))
		else $error("Move to the config address did not load it.");

	chk_cfg_file: assert property (
		cfg_file_wr |=> cfg_out == $past(file_wr_data_in))
		else $error("File write to the config register was lost.");

	chk_nop_quiet: assert property (
		act && is_nop |-> !file_we_out && !stack_pop_out && pc_advance_out)
		else $error("No-op had an effect.");

	chk_nop_taken: assert property (
		nop_taken |-> ##3 (!file_we_out && !stack_pop_out &&
			!pc_load_out && pc_advance_out))
		else $error("No-op did not just advance in Q4.");

	chk_nop_stable: assert property (
		act && is_nop && !cfg_file_wr |=> $stable(cfg_out))
		else $error("No-op changed the config register.");

	chk_pop_q4: assert property (
		file_we_out || stack_pop_out |-> phase == PH_Q4)
		else $error("Write or pop outside Q4.");

	chk_nop_one: assert property (
		act && is_nop |=> !second)
		else $error("No-op took two cycles.");

	chk_ret_taken: assert property (
		ret_taken |-> ##2 global_en_set_out ##1 ret_pop_q4)
		else $error("Return did not enable then pop.");

	chk_ret_target: assert property (
		ret_taken |-> ##3 pc_value_out == $past(stack_top_in))
		else $error("Return did not load the stack top.");

	chk_busy_span: assert property (
		ret_taken |-> (!busy_out)[*4] ##1 busy_out[*4] ##1 !busy_out)
		else $error("Return did not stay busy for one whole cycle.");
endmodule : misc_instr_exec_subset

// *** tb/prog_mem.sv ***
`timescale 1ns/1ps
module prog_mem
	import exec_pkg::*;
(
	input  wire logic [1:0]         kind_in,
	input  wire logic [ADDR_W-1:0]  operand_in,
	output logic      [INSTR_W-1:0] word_out
);
	// Low operand bits fill the no-op's don't-care field.
	always_comb begin
		case (kind_in)
			2'h0: word_out = {MOVE_ACC_OP, operand_in};
			2'h1: word_out = NOP_CODE | {7'h00, operand_in[1:0], 5'h00};
			2'h2: word_out = LOAD_CFG_CODE;
			default: word_out = IRQ_RET_CODE;
		endcase
	end
endmodule : prog_mem

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import exec_pkg::*;
	logic clock_in = 0, rst_in = 1, file_wr_in = 0, g_seen = 0;
	logic [1:0] kind = 2'h1, phase_out;
	logic [6:0] opnd = 0, file_wr_addr_in = 0, file_rd_addr_in = 0;
	logic [7:0] acc_in = 0, file_wr_data_in = 0;
	logic [12:0] stack_top_in = 0, pc_value_out;
	logic [13:0] instr_in;
	logic file_we_out, stack_pop_out, pc_load_out, pc_advance_out;
	logic global_en_set_out, busy_out, cfg_hit_out;
	logic [6:0] file_addr_out;
	logic [7:0] file_wdata_out, cfg_out, cfg_rdata_out;
	logic [32:0] notes[$];
	int error_cnt = 0, comparisons = 0, cycles = 0;
	prog_mem u_mem (.kind_in(kind), .operand_in(opnd), .word_out(instr_in));
	misc_instr_exec_subset u_dut (.clock_in, .rst_in, .instr_in, .acc_in,
		.stack_top_in, .file_wr_data_in, .file_wr_addr_in,
		.file_wr_in, .file_rd_addr_in, .phase_out, .file_we_out,
		.file_addr_out, .file_wdata_out, .cfg_out, .cfg_rdata_out,
		.cfg_hit_out, .stack_pop_out, .pc_load_out, .pc_value_out,
		.pc_advance_out, .global_en_set_out, .busy_out);
	initial begin
		forever #2.5 clock_in = ~clock_in;
	end
	task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		$display("Counts: %0d compared, %0d wrong", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	// Notes hold {enable set, write, pop, pc load, advance, addr, data, pc}.
	task automatic exec(logic [1:0] k, logic [6:0] op);
		logic [32:0] n;
		kind = k;
		opnd = op;
		acc_in = 8'($urandom);
		stack_top_in = 13'($urandom);
		case (k)
			2'h0: n = {5'b01001, op, acc_in, 13'h0000};
			2'h3: n = {5'b10110, 15'h0000, stack_top_in};
			default: n = {5'b00001, 28'h0};
		endcase
		notes.push_back(n);
		if (k == 2'h3) notes.push_back(33'h0);
		repeat (4) @(negedge clock_in);
		check("busy", 33'(busy_out), 33'(k == 2'h3));
		if (k == 2'h3) repeat (4) @(negedge clock_in);
	endtask : exec
	always @(negedge clock_in) begin
		logic [32:0] seen;
		if (phase_out == 2'h2) g_seen = global_en_set_out;
		seen = {g_seen, file_we_out, stack_pop_out, pc_load_out,
			pc_advance_out, file_we_out ? file_addr_out : 7'h00,
			file_we_out ? file_wdata_out : 8'h00,
			pc_load_out ? pc_value_out : 13'h0000};
		if (!rst_in && phase_out == 2'h3 && notes.size() > 0)
			check("effects", seen, notes.pop_front());
	end
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 400) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(59376));
		repeat (2) @(negedge clock_in);
		rst_in = 0;
		check("cfg reset", 33'(cfg_out), 33'(CFG_RESET));
		for (int i = 0; i < 4; i++) exec(2'h1, 7'(i));
		check("cfg after nop", 33'(cfg_out), 33'(CFG_RESET));
		$display("test done: no-op");
		exec(2'h0, 7'h7F);
		check("cfg after move", 33'(cfg_out), 33'(CFG_RESET));
		exec(2'h2, 7'h00);
		check("cfg load", 33'(cfg_out), 33'(acc_in));
		exec(2'h3, 7'h00);
		exec(2'h0, CFG_ADDR);
		check("cfg by move", 33'(cfg_out), 33'(acc_in));
		$display("test done: instructions");
		kind = 2'h1;
		notes.push_back({5'b00001, 28'h0});
		file_wr_in = 1;
		file_wr_addr_in = CFG_ADDR;
		file_wr_data_in = 8'($urandom);
		@(negedge clock_in);
		file_wr_in = 0;
		file_rd_addr_in = CFG_ADDR;
		@(negedge clock_in);
		check("cfg hit", 33'(cfg_hit_out), 33'h1);
		check("cfg read", 33'(cfg_rdata_out), 33'(file_wr_data_in));
		file_rd_addr_in = CFG_ADDR ^ 7'h40;
		@(negedge clock_in);
		check("cfg miss", 33'(cfg_hit_out), 33'h0);
		repeat (2) @(negedge clock_in);
		check("notes left", 33'(notes.size()), 33'h0);
		$display("test done: file access");
		complete_run();
	end
endmodule : testbench
